/* verilog/cmp_params.svh */
`ifndef CMP_PARAMS_SVH
`define CMP_PARAMS_SVH
// Behaviour
// - An enabled comparator keeps running and driving its output while the device sleeps.
// - Mode codes 000 and 111 switch both comparators off.
// - A comparator output change during sleep can wake the device.
// - Wake needs the comparator interrupt enable and the peripheral interrupt enable set.
// - After a comparator wake the instruction after sleep executes first.
// - With global interrupt enable set, the interrupt vector follows that instruction.
// - Reset returns both configuration registers to reset values: comparators off, inputs analog.
// - Output bits 6 and 7 show each comparator's result, flipped by its invert bit.
// - Invert bits 4 and 5 invert their comparator output; clear leaves it non-inverted.
// - The switch bit reroutes the inverting inputs of both comparators in four-input mode, and of comparator one only in three-input mode.
// - The comparator interrupt flag sets whenever the mismatch circuit sees an output change.
// - Every read of the configuration register reloads the mismatch reference latch.

// Register offsets
`define CMP_OFF_CFG 4'h0
`define CMP_OFF_AUX 4'h1
`define CMP_OFF_STAT 4'h2
`define CMP_OFF_MASK 4'h3
`define CMP_OFF_ICTL 4'h4

// Reset values
`define CMP_MODE_RST 3'h0
`define CMP_AUX_RST 2'h2
`define CMP_BYTE_ZERO 8'h00

// Mode codes
`define CMP_MODE_OFF0 3'h0
`define CMP_MODE_MUX3 3'h1
`define CMP_MODE_MUX4 3'h2
`define CMP_MODE_PINS 3'h6
`define CMP_MODE_OFF7 3'h7

// Interrupt control bit positions
`define CMP_B_PERIPHERAL_IRQ_ENABLE 0
`define CMP_B_GIE 1
`endif

/* verilog/cmp_pkg.sv */
package cmp_pkg;
   typedef enum logic [1:0] {
      CMP_ST_RUN,
      CMP_ST_SLEEP,
      CMP_ST_EXEC,
      CMP_ST_VECT
   } cmp_state_t;

   typedef struct packed {
      logic out2;
      logic out1;
      logic inv2;
      logic inv1;
      logic input_switch_select;
      logic [2:0] mode;
   } cmp_cfg_t;
endpackage

/* verilog/cmp_chan_if.sv */
interface cmp_chan_if;
   logic raw;
   logic en;
   logic inv;
   logic cap;
   logic out;
   logic mism;

   modport core (
      output raw,
      output en,
      output inv,
      output cap,
      input out,
      input mism
   );

   modport chan (
      input raw,
      input en,
      input inv,
      input cap,
      output out,
      output mism
   );
endinterface

/* verilog/cmp_chan.sv */
module cmp_chan
   import cmp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Channel
   cmp_chan_if.chan ch
);
   logic out_q;
   logic ref_q;
   logic next_out;

   // Polarity applied to the live result
   assign next_out = (ch.raw & ch.en) ^ ch.inv;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         out_q <= 1'b0;
         ref_q <= 1'b0;
      end else begin
         out_q <= next_out;
         if (ch.cap) begin
            ref_q <= out_q;
         end
      end
   end

   assign ch.out = out_q;
   assign ch.mism = out_q ^ ref_q;

   a_out_polarity:
   assert property (@(posedge clk_i) disable iff (srst_i)
      ##1 out_q == $past((ch.raw & ch.en) ^ ch.inv, 1))
   else $error("comparator output polarity wrong");

   a_read_reloads:
   assert property (@(posedge clk_i) disable iff (srst_i)
      ch.cap && (out_q == next_out) |=> !ch.mism)
   else $error("mismatch survives a reference reload");
endmodule

/* verilog/cmp_ctrl.sv */
`include "cmp_params.svh"

module cmp_ctrl
   import cmp_pkg::*;
#(
   parameter int NCH = 2,
   parameter int AW = 4,
   parameter int DW = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Register port
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [DW-1:0] rdata_o,
   // Analog comparator side
   input wire logic [NCH-1:0] cmp_raw_i,
   output logic [NCH-1:0] cmp_en_o,
   output logic c1_vneg_sw_o,
   output logic c2_vneg_sw_o,
   output logic analog_in_o,
   // Comparator output pins
   output logic [NCH-1:0] cmp_pin_o,
   output logic cmp_pin_oe_o,
   // Core sleep and wake
   input wire logic sleep_req_i,
   output logic sleeping_o,
   output logic wake_o,
   output logic exec_next_o,
   output logic vector_o,
   // Interrupt
   output logic irq_o
);
   cmp_chan_if ch [NCH] ();

   // Register storage
   logic [2:0] mode;
   logic input_switch_select;
   logic [NCH-1:0] inv;
   logic [1:0] aux;
   logic [NCH-1:0] flag;
   logic [NCH-1:0] mask;
   logic peripheral_irq_enable;
   logic global_irq_enable;
   cmp_state_t state;
   cmp_state_t next_state;

   // Per-channel live results
   wire [NCH-1:0] live_out;
   wire [NCH-1:0] mism;

   // Address decode
   wire sel_cfg = (addr_i == `CMP_OFF_CFG);
   wire sel_aux = (addr_i == `CMP_OFF_AUX);
   wire sel_stat = (addr_i == `CMP_OFF_STAT);
   wire sel_mask = (addr_i == `CMP_OFF_MASK);
   wire sel_ictl = (addr_i == `CMP_OFF_ICTL);
   wire wr_cfg = we_i & sel_cfg;
   wire wr_aux = we_i & sel_aux;
   wire wr_stat = we_i & sel_stat;
   wire wr_mask = we_i & sel_mask;
   wire wr_ictl = we_i & sel_ictl;
   // A write starts with a read, so both reload the reference
   wire cfg_touch = (re_i | we_i) & sel_cfg;

   // Mode decode
   wire mode_off = (mode == `CMP_MODE_OFF0) | (mode == `CMP_MODE_OFF7);
   wire mode_mux3 = (mode == `CMP_MODE_MUX3);
   wire mode_mux4 = (mode == `CMP_MODE_MUX4);
   wire mode_pins = (mode == `CMP_MODE_PINS);

   // Sleep does not gate the enables
   assign cmp_en_o = mode_off ? {NCH{1'b0}} : {NCH{1'b1}};
   assign c1_vneg_sw_o = input_switch_select & (mode_mux3 | mode_mux4);
   assign c2_vneg_sw_o = input_switch_select & mode_mux4;
   assign analog_in_o = (mode != `CMP_MODE_OFF7);
   assign cmp_pin_oe_o = mode_pins;
   assign cmp_pin_o = mode_pins ? live_out : {NCH{1'b0}};

   // Channel instances
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         assign ch[g].raw = cmp_raw_i[g];
         assign ch[g].en = cmp_en_o[g];
         assign ch[g].inv = inv[g];
         assign ch[g].cap = cfg_touch;
         assign live_out[g] = ch[g].out;
         assign mism[g] = ch[g].mism;
         cmp_chan u_chan (
            .clk_i (clk_i),
            .srst_i (srst_i),
            .ch (ch[g])
         );
      end
   endgenerate

   // Configuration register view
   cmp_cfg_t cfg_view;
   assign cfg_view.out2 = live_out[1];
   assign cfg_view.out1 = live_out[0];
   assign cfg_view.inv2 = inv[1];
   assign cfg_view.inv1 = inv[0];
   assign cfg_view.input_switch_select = input_switch_select;
   assign cfg_view.mode = mode;

   // Write decode of configuration fields; output bits are dropped
   cmp_cfg_t cfg_wr_data;
   assign cfg_wr_data = cmp_cfg_t'(wdata_i);

   // Status next value: set wins over write-one-to-clear
   wire [NCH-1:0] stat_clr = wr_stat ? wdata_i[NCH-1:0] : {NCH{1'b0}};
   wire [NCH-1:0] next_flag = (flag & ~stat_clr) | mism;

   // Read multiplexer
   wire [DW-1:0] rd_mux =
      sel_cfg ? DW'(cfg_view) :
      sel_aux ? DW'(aux) :
      sel_stat ? DW'(flag) :
      sel_mask ? DW'(mask) :
      sel_ictl ? DW'({global_irq_enable, peripheral_irq_enable}) :
      `CMP_BYTE_ZERO;

   // Configuration register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mode <= `CMP_MODE_RST;
         input_switch_select <= 1'b0;
         inv <= {NCH{1'b0}};
      end else if (wr_cfg) begin
         mode <= cfg_wr_data.mode;
         input_switch_select <= cfg_wr_data.input_switch_select;
         inv <= {cfg_wr_data.inv2, cfg_wr_data.inv1};
      end
   end

   // Auxiliary configuration register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         aux <= `CMP_AUX_RST;
      end else if (wr_aux) begin
         aux <= wdata_i[1:0];
      end
   end

   // Interrupt status, mask and control
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         flag <= {NCH{1'b0}};
         mask <= {NCH{1'b0}};
         peripheral_irq_enable <= 1'b0;
         global_irq_enable <= 1'b0;
      end else begin
         flag <= next_flag;
         if (wr_mask) begin
            mask <= wdata_i[NCH-1:0];
         end
         if (wr_ictl) begin
            peripheral_irq_enable <= wdata_i[`CMP_B_PERIPHERAL_IRQ_ENABLE];
            global_irq_enable <= wdata_i[`CMP_B_GIE];
         end
      end
   end

   // Read data, one cycle after the strobe only
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_o <= `CMP_BYTE_ZERO;
      end else begin
         rdata_o <= re_i ? rd_mux : `CMP_BYTE_ZERO;
      end
   end

   wire pending = |(flag & mask);
   assign irq_o = pending;

   // Wake needs a flagged, enabled comparator plus peripheral enable
   wire wake_cond = pending & peripheral_irq_enable;

   // Sleep and wake sequencer
   always_comb begin
      next_state = state;
      case (state)
         CMP_ST_RUN: begin
            if (sleep_req_i) begin
               next_state = CMP_ST_SLEEP;
            end
         end
         CMP_ST_SLEEP: begin
            if (wake_cond) begin
               next_state = CMP_ST_EXEC;
            end
         end
         CMP_ST_EXEC: begin
            next_state = global_irq_enable ? CMP_ST_VECT : CMP_ST_RUN;
         end
         CMP_ST_VECT: begin
            next_state = CMP_ST_RUN;
         end
         default: begin
            next_state = CMP_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= CMP_ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   assign sleeping_o = (state == CMP_ST_SLEEP);
   assign wake_o = sleeping_o & wake_cond;
   assign exec_next_o = (state == CMP_ST_EXEC);
   assign vector_o = (state == CMP_ST_VECT);

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   a_off_codes:
   assert property (mode_off |-> cmp_en_o == {NCH{1'b0}})
   else $error("comparator enabled in an off mode");

   a_sleep_active:
   assert property (sleeping_o && !mode_off |-> cmp_en_o == {NCH{1'b1}})
   else $error("enabled comparator stopped in sleep");

   a_wake_cause:
   assert property (wake_o |-> peripheral_irq_enable && |(flag & mask))
   else $error("wake without enabled comparator flag");

   a_wake_happens:
   assert property (sleeping_o && peripheral_irq_enable && |(flag & mask) |=> exec_next_o)
   else $error("comparator change did not wake the device");

   a_exec_first:
   assert property (wake_o |=> exec_next_o && !vector_o ##1 !exec_next_o)
   else $error("instruction after sleep not executed first");

   a_isr_branch:
   assert property (exec_next_o |=> vector_o == $past(global_irq_enable))
   else $error("vector branch does not follow global enable");

   a_reset_values:
   assert property (@(posedge clk_i) disable iff (1'b0)
      srst_i |=> mode == `CMP_MODE_RST && aux == `CMP_AUX_RST && cmp_en_o == {NCH{1'b0}} && analog_in_o)
   else $error("configuration not at reset state");

   a_read_polarity:
   assert property (re_i && sel_cfg |=> rdata_o[7:6] == $past(live_out))
   else $error("output status bits do not show live outputs");

   a_input_switch:
   assert property (mode_mux4 && input_switch_select |-> c1_vneg_sw_o && c2_vneg_sw_o)
   else $error("input switch not routed in four-input mode");

   a_flag_set:
   assert property (|mism |=> (flag & $past(mism)) == $past(mism))
   else $error("mismatch did not set the interrupt flag");

   a_cfg_capture:
   assert property (cfg_touch |=> mism == (live_out ^ $past(live_out)))
   else $error("reference reload check failed");

   a_status_ro:
   assert property (wr_cfg ##1 re_i && sel_cfg |=> rdata_o[7:6] == $past(live_out))
   else $error("write changed output status bits");

   c_wake_isr: cover property (wake_o ##1 exec_next_o ##1 vector_o);
   c_wake_plain: cover property (wake_o ##1 exec_next_o ##1 !vector_o);
   c_read_clear: cover property (|mism ##0 re_i && sel_cfg ##2 !(|mism));
   c_pin_mode: cover property (cmp_pin_oe_o && |cmp_pin_o);
endmodule

/* testbench/cmp_ctrl_tb.sv */
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin error_cnt++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, (act), (exp)); end end

module cmp_ctrl_tb
   import cmp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic we_i = 1'b0;
   logic re_i = 1'b0;
   logic [1:0] cmp_raw_i = 2'h0;
   logic sleep_req_i = 1'b0;
   logic [7:0] rdata_o;
   logic [1:0] cmp_en_o;
   logic c1_vneg_sw_o;
   logic c2_vneg_sw_o;
   logic analog_in_o;
   logic [1:0] cmp_pin_o;
   logic cmp_pin_oe_o;
   logic sleeping_o;
   logic wake_o;
   logic exec_next_o;
   logic vector_o;
   logic irq_o;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   logic [7:0] rd;

   cmp_ctrl i_cmp_ctrl (
      .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
      .rdata_o(rdata_o), .cmp_raw_i(cmp_raw_i), .cmp_en_o(cmp_en_o), .c1_vneg_sw_o(c1_vneg_sw_o),
      .c2_vneg_sw_o(c2_vneg_sw_o), .analog_in_o(analog_in_o), .cmp_pin_o(cmp_pin_o),
      .cmp_pin_oe_o(cmp_pin_oe_o), .sleep_req_i(sleep_req_i), .sleeping_o(sleeping_o), .wake_o(wake_o),
      .exec_next_o(exec_next_o), .vector_o(vector_o), .irq_o(irq_o)
   );

   always #10 clk_i = ~clk_i;

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask

   task automatic rdreg(input logic [3:0] a);
      @(posedge clk_i);
      addr_i <= a;
      re_i <= 1'b1;
      @(posedge clk_i);
      re_i <= 1'b0;
      #1;
      rd = rdata_o;
   endtask

   // Reload reference, then drop both flags
   task automatic clr_flags();
      rdreg(4'h0);
      wr(4'h2, 8'h03);
   endtask

   task automatic complete_run();
      $display("Checks %0d, errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         complete_run();
      end
   end

   initial begin
      int k;
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      rdreg(4'h0);
      `CHK(rd, 8'h00)
      rdreg(4'h1);
      `CHK(rd, 8'h02)
      `CHK(cmp_en_o, 2'h0)
      `CHK(analog_in_o, 1'b1)
      rdreg(4'h7);
      `CHK(rd, 8'h00)
      // Auxiliary register keeps two bits only
      wr(4'h1, 8'hFD);
      rdreg(4'h1);
      `CHK(rd, 8'h01)
      // Every mode code
      for (k = 0; k < 8; k++) begin
         wr(4'h0, 8'(k));
         #1;
         `CHK(cmp_en_o, ((k == 0 || k == 7) ? 2'h0 : 2'h3))
         `CHK(analog_in_o, (k != 7))
         `CHK(cmp_pin_oe_o, (k == 6))
      end
      // Polarity of both channels
      @(posedge clk_i);
      cmp_raw_i <= 2'h1;
      for (k = 0; k < 4; k++) begin
         wr(4'h0, 8'(k << 4) | 8'h02);
         rdreg(4'h0);
         `CHK(rd[7:6], (2'(k) ^ 2'h1))
      end
      wr(4'h0, 8'hC2);
      rdreg(4'h0);
      `CHK(rd, 8'h42)
      wr(4'h0, 8'h06);
      repeat (2) @(posedge clk_i);
      #1;
      `CHK(cmp_pin_o, 2'h1)
      wr(4'h0, 8'h0A);
      #1;
      `CHK({c2_vneg_sw_o, c1_vneg_sw_o}, 2'h3)
      wr(4'h0, 8'h09);
      #1;
      `CHK({c2_vneg_sw_o, c1_vneg_sw_o}, 2'h1)
      // Mismatch flag and interrupt
      wr(4'h0, 8'h02);
      cmp_raw_i <= 2'h0;
      repeat (2) @(posedge clk_i);
      clr_flags();
      wr(4'h3, 8'h03);
      rdreg(4'h2);
      `CHK(rd, 8'h00)
      `CHK(irq_o, 1'b0)
      @(posedge clk_i);
      cmp_raw_i <= 2'h2;
      repeat (3) @(posedge clk_i);
      #1;
      `CHK(irq_o, 1'b1)
      wr(4'h2, 8'h02);
      rdreg(4'h2);
      `CHK(rd, 8'h02)
      rdreg(4'h0);
      wr(4'h2, 8'h02);
      rdreg(4'h2);
      `CHK(rd, 8'h00)
      `CHK(irq_o, 1'b0)
      wr(4'h3, 8'h00);
      cmp_raw_i <= 2'h0;
      repeat (3) @(posedge clk_i);
      #1;
      `CHK(irq_o, 1'b0)
      rdreg(4'h2);
      `CHK(rd, 8'h02)
      // Sleep and wake, without and with global enable
      for (k = 0; k < 2; k++) begin
         clr_flags();
         wr(4'h4, 8'(k << 1));
         wr(4'h3, 8'h01);
         @(posedge clk_i);
         sleep_req_i <= 1'b1;
         @(posedge clk_i);
         sleep_req_i <= 1'b0;
         cmp_raw_i <= cmp_raw_i ^ 2'h1;
         repeat (3) @(posedge clk_i);
         #1;
         `CHK(sleeping_o, 1'b1)
         `CHK(wake_o, 1'b0)
         `CHK(cmp_en_o, 2'h3)
         rdreg(4'h2);
         `CHK(rd, 8'h01)
         wr(4'h4, 8'(k << 1) | 8'h01);
         #1;
         for (int n = 0; n < 10 && wake_o !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
         end
         `CHK(wake_o, 1'b1)
         @(posedge clk_i);
         #1;
         `CHK(exec_next_o, 1'b1)
         `CHK(vector_o, 1'b0)
         @(posedge clk_i);
         #1;
         `CHK(vector_o, (k == 1))
         repeat (2) @(posedge clk_i);
         #1;
         `CHK(sleeping_o, 1'b0)
      end
      rdreg(4'h4);
      `CHK(rd, 8'h03)
      rdreg(4'h3);
      `CHK(rd, 8'h01)
      // Reset in mid-run restores aux, mask, control and configuration registers
      @(posedge clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      rdreg(4'h1);
      `CHK(rd, 8'h02)
      rdreg(4'h3);
      `CHK(rd, 8'h00)
      rdreg(4'h4);
      `CHK(rd, 8'h00)
      rdreg(4'h0);
      `CHK(rd, 8'h00)
      `CHK(cmp_en_o, 2'h0)
      `CHK(analog_in_o, 1'b1)
      complete_run();
   end
endmodule
